// file: common/pmc_defs.vh
// Constants for the power-mode and emulation-mode controller.
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// Oscillator periods in one machine cycle.
`define PMC_OSC_PER_MC      12
// Machine cycles the reset input must stay high before it is accepted.
`define PMC_RST_HOLD_MC     2
// Phase-clock enables (half oscillator rate) needed to qualify a reset.
`define PMC_RST_HOLD_CNT    5'h0C
// Phase-clock enables in the post-Idle execution window (two machine cycles).
`define PMC_IDLE_RUN_CNT    5'h0C
// Oscillator restart time in microseconds.
`define PMC_OSC_START_US    10000
// Reference clock rate in MHz.
`define PMC_CLK_MHZ         25
// Mode state codes.
`define PMC_ST_RUN          3'h0
`define PMC_ST_IDLE         3'h1
`define PMC_ST_PDOWN        3'h2
`define PMC_ST_WAKE         3'h3
`define PMC_ST_RESET        3'h4
`define PMC_ST_IDLERST      3'h5
`endif

// file: hw/pmc_power_mode_controller.v
// Power-mode and emulation-mode controller of a small 8-bit microcontroller.
`timescale 1ns/1ns
`include "pmc_defs.vh"

module pmc_power_mode_controller #(
  parameter OSC_START_CYC = `PMC_OSC_START_US * `PMC_CLK_MHZ
) (
  input  wire       ref_clk,          // Reference clock that samples the oscillator input.
  input  wire       srst,             // Synchronous reset of this controller.
  input  wire       osc_in,           // Oscillator level from the crystal pin.
  input  wire       rstPin,           // Chip reset pin, active high.
  input  wire       idleReq,          // One-cycle request from the core to enter Idle.
  input  wire       pdownReq,         // One-cycle request from the core to enter Power Down.
  input  wire       irqPending,       // Any enabled interrupt is active.
  input  wire       ext_irq_zero_n,   // External interrupt zero pin, low active.
  input  wire       ext_irq_one_n,    // External interrupt one pin, low active.
  input  wire       extIrqEnable,     // Both external interrupts enabled and level-sensitive.
  input  wire       extProgMem,       // Program memory is external.
  input  wire       returnFromIrq,    // Core has executed return_from_interrupt.
  input  wire       aleIn,            // Level sensed on the address latch strobe pin.
  input  wire       progFetchIn,      // Level sensed on the prog_fetch_strobe pin.
  output reg        phaseEn,          // Divide-by-two phase clock enable.
  output reg        osc_out,          // Drive to the oscillator amplifier output.
  output reg        coreRun,          // Core may execute instructions.
  output reg        coreReset,        // Internal reset to core and special_regs.
  output reg        ramBlock,         // Internal RAM access inhibited.
  output reg        wakeIrq,          // Core must vector to the wake-up interrupt.
  output reg        resumeAfterPd,    // Pulse: resume after the Power Down instruction.
  output reg        emulMode,         // Emulation mode is active.
  output reg        strobeForce,      // Strobes and ports are forced by this block.
  output reg        aleOut,           // Address latch strobe level when forced.
  output reg        aleOe_n,          // Address latch strobe output enable, low drives.
  output reg        progFetchOut,     // prog_fetch_strobe level when forced.
  output reg        progFetchOe_n,    // prog_fetch_strobe output enable, low drives.
  output reg        weakPullup,       // Ports and strobes weakly pulled high.
  output reg        port0Float,       // Port zero released to high impedance.
  output reg        port2Addr,        // Port two keeps driving address.
  output reg [2:0]  modeState         // Current mode state.
);

  reg        divFlop_r;               // Divide-by-two flip-flop.
  reg        oscEn_r;                 // Oscillator running.
  reg  [2:0] state_r;                 // Mode state.
  reg  [4:0] rstCnt_r;                // Reset hold count in phase enables.
  reg  [4:0] runCnt_r;                // Post-Idle execution window count.
  reg [31:0] startCnt_r;              // Oscillator restart counter.
  reg        pdWake_r;                // Power Down ended by interrupt, awaiting return.
  reg        aleLowInRst_r;           // Strobe seen low during reset with fetch strobe high.
  reg        oscPrev_r;               // Oscillator level seen at the previous clock.

  wire extIrqLow = extIrqEnable & (~ext_irq_zero_n | ~ext_irq_one_n);
  wire rstQual   = (rstCnt_r == `PMC_RST_HOLD_CNT);
  wire oscRise   = osc_in & ~oscPrev_r;  // Rising edge of the oscillator input.

  // Only rising edges of the incoming oscillator toggle the divider flip-flop, so a
  // long high or low time of an external clock never adds extra phase enables.
  always @(posedge ref_clk) begin
    if (srst) begin
      divFlop_r <= 1'b0;
      phaseEn   <= 1'b0;
      osc_out   <= 1'b0;
      // Starting high hides a level that is already high, so no false edge follows reset.
      oscPrev_r <= 1'b1;
    end else begin
      oscPrev_r <= osc_in;
      osc_out   <= oscEn_r & ~osc_in;
      phaseEn   <= oscEn_r & oscRise & ~divFlop_r;
      if (oscEn_r & oscRise)
        divFlop_r <= ~divFlop_r;
      else
        divFlop_r <= divFlop_r;
    end
  end

  // Reset pin is accepted only after two machine cycles of running oscillator.
  always @(posedge ref_clk) begin
    if (srst) begin
      rstCnt_r <= 5'h00;
    end else if (!rstPin) begin
      rstCnt_r <= 5'h00;
    end else if (phaseEn && !rstQual) begin
      rstCnt_r <= rstCnt_r + 5'h01;
    end
  end

  // Main mode sequencer.
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r       <= `PMC_ST_RESET;
      oscEn_r       <= 1'b1;
      runCnt_r      <= 5'h00;
      startCnt_r    <= 32'h00000000;
      pdWake_r      <= 1'b0;
      resumeAfterPd <= 1'b0;
      aleLowInRst_r <= 1'b0;
      emulMode      <= 1'b0;
    end else begin
      resumeAfterPd <= 1'b0;
      case (state_r)
        `PMC_ST_RUN: begin
          if (rstQual)
            state_r <= `PMC_ST_RESET;
          else if (pdownReq) begin
            state_r <= `PMC_ST_PDOWN;
            oscEn_r <= 1'b0;
          end else if (idleReq)
            state_r <= `PMC_ST_IDLE;
          if (pdWake_r && returnFromIrq) begin
            pdWake_r      <= 1'b0;
            resumeAfterPd <= 1'b1;
          end
        end
        `PMC_ST_IDLE: begin
          if (rstPin) begin
            state_r  <= `PMC_ST_IDLERST;
            runCnt_r <= 5'h00;
          end else if (irqPending)
            state_r <= `PMC_ST_RUN;
        end
        `PMC_ST_IDLERST: begin
          if (runCnt_r == `PMC_IDLE_RUN_CNT || rstQual)
            state_r <= `PMC_ST_RESET;
          else if (phaseEn)
            runCnt_r <= runCnt_r + 5'h01;
        end
        `PMC_ST_PDOWN: begin
          // Only reset or a low external interrupt restarts the oscillator.
          if (rstPin || extIrqLow) begin
            oscEn_r    <= 1'b1;
            startCnt_r <= 32'h00000000;
            state_r    <= `PMC_ST_WAKE;
          end
        end
        `PMC_ST_WAKE: begin
          // The source must stay active while the oscillator settles.
          if (startCnt_r < OSC_START_CYC)
            startCnt_r <= startCnt_r + 32'h00000001;
          if (rstQual)
            state_r <= `PMC_ST_RESET;
          else if (!rstPin && !extIrqLow && startCnt_r >= OSC_START_CYC) begin
            state_r  <= `PMC_ST_RUN;
            pdWake_r <= 1'b1;
          end
        end
        `PMC_ST_RESET: begin
          pdWake_r <= 1'b0;
          // The strobe held low through reset with fetch strobe high selects emulation.
          if (rstPin) begin
            aleLowInRst_r <= ~aleIn & progFetchIn;
            emulMode      <= 1'b0;
          end else begin
            emulMode <= aleLowInRst_r & ~aleIn;
            state_r  <= `PMC_ST_RUN;
          end
        end
        default: state_r <= `PMC_ST_RESET;
      endcase
    end
  end

  // Pin and core control derived from the mode state.
  always @(posedge ref_clk) begin
    if (srst) begin
      // The core is held in reset and every pin is left to the port logic.
      coreRun       <= 1'b0;
      coreReset     <= 1'b1;
      ramBlock      <= 1'b0;
      wakeIrq       <= 1'b0;
      strobeForce   <= 1'b0;
      aleOut        <= 1'b1;
      aleOe_n       <= 1'b1;
      progFetchOut  <= 1'b1;
      progFetchOe_n <= 1'b1;
      weakPullup    <= 1'b0;
      port0Float    <= 1'b0;
      port2Addr     <= 1'b0;
      modeState     <= `PMC_ST_RESET;
    end else begin
      modeState <= state_r;
      coreRun   <= (state_r == `PMC_ST_RUN) | (state_r == `PMC_ST_IDLERST);
      coreReset <= (state_r == `PMC_ST_RESET);
      ramBlock  <= (state_r == `PMC_ST_IDLERST);
      wakeIrq   <= pdWake_r;
      if (emulMode && state_r == `PMC_ST_RUN) begin
        // Emulation: both strobes are released to their weak pull-ups and port zero floats.
        strobeForce   <= 1'b1;
        aleOut        <= 1'b1;
        aleOe_n       <= 1'b1;
        progFetchOut  <= 1'b1;
        progFetchOe_n <= 1'b1;
        weakPullup    <= 1'b1;
        port0Float    <= 1'b1;
        port2Addr     <= 1'b0;
      end else if (state_r == `PMC_ST_IDLE) begin
        // Idle: strobes driven high; with external code port two keeps the address.
        strobeForce   <= 1'b1;
        aleOut        <= 1'b1;
        aleOe_n       <= 1'b0;
        progFetchOut  <= 1'b1;
        progFetchOe_n <= 1'b0;
        weakPullup    <= 1'b0;
        port0Float    <= extProgMem;
        port2Addr     <= extProgMem;
      end else if (state_r == `PMC_ST_PDOWN || state_r == `PMC_ST_WAKE) begin
        // Power Down and wake-up: strobes driven low; port zero floats with external code, other ports hold data.
        strobeForce   <= 1'b1;
        aleOut        <= 1'b0;
        aleOe_n       <= 1'b0;
        progFetchOut  <= 1'b0;
        progFetchOe_n <= 1'b0;
        weakPullup    <= 1'b0;
        port0Float    <= extProgMem;
        port2Addr     <= 1'b0;
      end else begin
        // Running or in reset: the port logic of the core owns every pin.
        strobeForce   <= 1'b0;
        aleOut        <= 1'b1;
        aleOe_n       <= 1'b1;
        progFetchOut  <= 1'b1;
        progFetchOe_n <= 1'b1;
        weakPullup    <= 1'b0;
        port0Float    <= 1'b0;
        port2Addr     <= 1'b0;
      end
    end
  end

endmodule

// file: verification/pmc_checker.sv
// Port-level assertions for the power-mode controller.
`timescale 1ns/1ns
`include "pmc_defs.vh"
module pmc_checker (
  input wire       ref_clk,
  input wire       srst,
  input wire       rstPin,
  input wire       idleReq,
  input wire       pdownReq,
  input wire       phaseEn,
  input wire       coreRun,
  input wire       coreReset,
  input wire       resumeAfterPd,
  input wire       emulMode,
  input wire       aleOut,
  input wire       progFetchOut,
  input wire       weakPullup,
  input wire       port0Float,
  input wire [2:0] modeState
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  idle_entry_a:
    assert property (modeState == 3'h0 && idleReq && !pdownReq && !rstPin |-> ##3 modeState == 3'h1)
    else $error("Idle not entered");
  pdown_entry_a:
    assert property (modeState == 3'h0 && pdownReq && !rstPin |-> ##3 modeState == 3'h2)
    else $error("Power down not entered");
  pdown_strobe_a:
    assert property (modeState == 3'h2 && $past(modeState) == 3'h2 |-> !aleOut && !progFetchOut)
    else $error("Strobes not low in power down");
  idle_strobe_a:
    assert property (modeState == 3'h1 && $past(modeState) == 3'h1 |-> aleOut && progFetchOut && !coreRun)
    else $error("Idle pins wrong");
  clock_stop_a:
    assert property (modeState == 3'h2 && $past(modeState, 2) == 3'h2 |-> !phaseEn && !coreRun)
    else $error("Clock runs in power down");
  phase_div_a:
    assert property (phaseEn |=> !phaseEn) else $error("Phase enable not divided");
  reset_hold_a:
    assert property ($rose(rstPin) && modeState == 3'h0 && !coreReset |=> !coreReset [*8])
    else $error("Short reset accepted");
  core_reset_a:
    assert property (modeState == 3'h4 |-> coreReset) else $error("Core not reset");
  emul_pins_a:
    assert property (emulMode && modeState == 3'h0 && $past(modeState) == 3'h0 |-> port0Float && weakPullup)
    else $error("Emulation pins wrong");
  resume_pulse_a:
    assert property (resumeAfterPd |=> !resumeAfterPd) else $error("Resume pulse too long");
  cover property (modeState == 3'h1);
  cover property (modeState == 3'h3);
  cover property (emulMode);
  cover property (resumeAfterPd);
endmodule

// file: verification/pmc_far_side.sv
// Far-side model: clock source, wake pins and emulator pod.
`timescale 1ns/1ns
module pmc_far_side (
  input  wire ref_clk,
  input  wire irqLow,
  input  wire emulReq,
  input  wire aleOut,
  input  wire aleOe_n,
  input  wire progFetchOut,
  input  wire progFetchOe_n,
  output reg  osc_in = 1'b0,
  output reg  irqZero_n = 1'b1,
  output reg  irqOne_n = 1'b1,
  output wire aleIn,
  output wire progFetchIn
);
  // External clock with an uneven duty cycle, high two cycles and low one, so a
  // divider that counted levels instead of edges would run too fast.
  reg [1:0] oscPhase = 2'h0; // Position within one oscillator period.
  always @(posedge ref_clk) begin
    oscPhase <= (oscPhase == 2'h2) ? 2'h0 : oscPhase + 2'h1;
    osc_in   <= (oscPhase != 2'h0);
  end
  // Wake pins idle high and are held low as long as the bench asks.
  always @(posedge ref_clk) begin
    irqZero_n <= ~irqLow;
    irqOne_n <= ~irqLow;
  end
  // The device wins when it drives; else the pod pulls the strobe low or a pull-up holds it.
  assign aleIn = !aleOe_n ? aleOut : ~emulReq;
  assign progFetchIn = !progFetchOe_n ? progFetchOut : 1'b1;
endmodule

// file: verification/pmc_power_mode_controller_bench.sv
// Self-checking bench of the power-mode controller.
`timescale 1ns/1ns
module pmc_power_mode_controller_bench;
  reg ref_clk = 0, srst = 1, rstPin = 0, idleReq = 0, pdownReq = 0, irqPending = 0;
  reg extIrqEnable = 1, extProgMem = 1, returnFromIrq = 0, irqLow = 0, emulReq = 0;
  wire osc_in, irqZero_n, irqOne_n, aleIn, progFetchIn, phaseEn, coreRun, coreReset, ramBlock;
  wire wakeIrq, resumeAfterPd, emulMode, aleOut, aleOe_n, progFetchOut, progFetchOe_n;
  wire weakPullup, port0Float, oscOut, strobeForce, port2Addr;
  wire [2:0] modeState;
  integer fail_count = 0, samples_checked = 0, n;
  always #20 ref_clk = ~ref_clk;
  pmc_power_mode_controller #(.OSC_START_CYC(20)) pmc_power_mode_controller_i (
    .ref_clk(ref_clk), .srst(srst), .osc_in(osc_in), .rstPin(rstPin), .idleReq(idleReq),
    .pdownReq(pdownReq), .irqPending(irqPending), .ext_irq_zero_n(irqZero_n),
    .ext_irq_one_n(irqOne_n), .extIrqEnable(extIrqEnable), .extProgMem(extProgMem),
    .returnFromIrq(returnFromIrq), .aleIn(aleIn), .progFetchIn(progFetchIn),
    .phaseEn(phaseEn), .osc_out(oscOut), .coreRun(coreRun), .coreReset(coreReset),
    .ramBlock(ramBlock), .wakeIrq(wakeIrq), .resumeAfterPd(resumeAfterPd),
    .emulMode(emulMode), .strobeForce(strobeForce), .aleOut(aleOut), .aleOe_n(aleOe_n),
    .progFetchOut(progFetchOut), .progFetchOe_n(progFetchOe_n), .weakPullup(weakPullup),
    .port0Float(port0Float), .port2Addr(port2Addr), .modeState(modeState));
  pmc_far_side pmc_far_side_i (.ref_clk(ref_clk), .irqLow(irqLow), .emulReq(emulReq),
    .aleOut(aleOut), .aleOe_n(aleOe_n), .progFetchOut(progFetchOut),
    .progFetchOe_n(progFetchOe_n), .osc_in(osc_in), .irqZero_n(irqZero_n),
    .irqOne_n(irqOne_n), .aleIn(aleIn), .progFetchIn(progFetchIn));
  // Counts a comparison and reports a mismatch.
  task chk(input ok, input [8*24-1:0] msg);
    begin
      samples_checked = samples_checked + 1;
      if (!ok) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: %0s", $time, msg);
      end
    end
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(posedge ref_clk);
      #1;
    end
  endtask
  // Waits, bounded, for a mode state.
  task waitSt(input [2:0] s);
    begin
      n = 0;
      while (modeState !== s && n < 300) begin
        cyc(1);
        n = n + 1;
      end
      chk(modeState === s, "mode state not reached");
    end
  endtask
  // Holds the reset pin for 100 cycles, longer than 12 phase enables, then releases it.
  task hardReset;
    begin
      @(posedge ref_clk) rstPin <= 1;
      cyc(100);
      chk(coreReset === 1'b1, "core not in reset");
      @(posedge ref_clk) rstPin <= 0;
      waitSt(3'h0);
      cyc(2);
    end
  endtask
  task req(input pd);
    begin
      @(posedge ref_clk) {pdownReq, idleReq} <= {pd, ~pd};
      @(posedge ref_clk) {pdownReq, idleReq} <= 2'b00;
      waitSt(pd ? 3'h2 : 3'h1);
      cyc(2);
    end
  endtask
  task testIdle;
    begin
      // The first Idle runs from external program memory: core stops, strobes are driven high.
      req(0);
      chk(coreRun === 1'b0 && aleOut === 1'b1 && progFetchOut === 1'b1, "idle");
      chk(port0Float === 1'b1 && port2Addr === 1'b1, "external idle ports");
      chk(strobeForce === 1'b1 && aleOe_n === 1'b0, "idle strobes not driven");
      @(posedge ref_clk) irqPending <= 1;
      waitSt(3'h0);
      // The second Idle runs from internal program memory.
      @(posedge ref_clk) {irqPending, extProgMem} <= 2'b00;
      req(0);
      chk(port0Float === 1'b0 && port2Addr === 1'b0, "internal idle ports");
      @(posedge ref_clk) rstPin <= 1;
      waitSt(3'h5);
      chk(ramBlock === 1'b1 && coreRun === 1'b1, "ram open in window");
      hardReset;
    end
  endtask
  task testPdown;
    begin
      req(1);
      cyc(8);
      chk(aleOut === 1'b0 && progFetchOut === 1'b0 && phaseEn === 1'b0, "pdown");
      chk(oscOut === 1'b0 && coreRun === 1'b0, "oscillator runs");
      chk(port0Float === 1'b0 && port2Addr === 1'b0, "internal pdown ports");
      @(posedge ref_clk) irqLow <= 1;
      waitSt(3'h3);
      cyc(40);
      @(posedge ref_clk) irqLow <= 0;
      waitSt(3'h0);
      cyc(1);
      chk(wakeIrq === 1'b1 && coreReset === 1'b0, "wake irq missing");
      @(posedge ref_clk) returnFromIrq <= 1;
      @(posedge ref_clk) returnFromIrq <= 0;
      #1;
      n = 0;
      while (resumeAfterPd !== 1'b1 && n < 5) begin
        cyc(1);
        n = n + 1;
      end
      chk(resumeAfterPd === 1'b1, "no resume pulse");
      cyc(1);
      chk(wakeIrq === 1'b0, "wake irq kept");
      // The second Power Down runs from external program memory.
      @(posedge ref_clk) extProgMem <= 1;
      req(1);
      chk(port0Float === 1'b1 && port2Addr === 1'b0, "external pdown ports");
      hardReset;
    end
  endtask
  task testEmul;
    begin
      @(posedge ref_clk) emulReq <= 1;
      hardReset;
      chk(emulMode === 1'b1 && port0Float === 1'b1 && weakPullup === 1'b1, "emul");
      chk(aleOe_n === 1'b1 && progFetchOe_n === 1'b1, "emul strobes driven");
      @(posedge ref_clk) emulReq <= 0;
      hardReset;
      chk(emulMode === 1'b0, "emulation kept");
    end
  endtask
  task test_done;
    begin
      $display("Checks %0d, errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 0;
    waitSt(3'h0);
    testIdle;
    testPdown;
    testEmul;
    test_done;
  end
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    #200000;
    fail_count = fail_count + 1;
    test_done;
  end
endmodule
bind pmc_power_mode_controller pmc_checker pmc_checker_i (.ref_clk(ref_clk), .srst(srst),
  .rstPin(rstPin), .idleReq(idleReq), .pdownReq(pdownReq), .phaseEn(phaseEn),
  .coreRun(coreRun), .coreReset(coreReset), .resumeAfterPd(resumeAfterPd),
  .emulMode(emulMode), .aleOut(aleOut), .progFetchOut(progFetchOut),
  .weakPullup(weakPullup), .port0Float(port0Float), .modeState(modeState));
